// File: asr_pkg.sv
// Package for the asynchronous byte-wide SRAM controller
package asr_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int ASR_ADDR_W = 20;
    localparam int ASR_DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;

    // ****************************************
    // Speed grades
    // ****************************************
    typedef enum logic [1:0] {
        ASR_GRADE_45,
        ASR_GRADE_55,
        ASR_GRADE_70
    } asr_grade_e;

    // Timing per grade, ns as printed
    localparam int T_RC_45  = 45;
    localparam int T_RC_55  = 55;
    localparam int T_RC_70  = 70;
    localparam int T_DOE_F  = 25;
    localparam int T_DOE_S  = 35;
    localparam int T_HZOE_45 = 15;
    localparam int T_HZOE_55 = 20;
    localparam int T_HZOE_70 = 25;
    localparam int T_AW_F   = 40;
    localparam int T_AW_S   = 60;
    localparam int T_PWE_45 = 35;
    localparam int T_PWE_55 = 40;
    localparam int T_PWE_70 = 45;
    localparam int T_SD_F   = 25;
    localparam int T_SD_S   = 30;
    localparam int T_HD     = 0;
    localparam int T_SA     = 0;

    // Least time in cycles, rounded up, at least one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic                  write;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_s;

    typedef struct packed {
        logic                  ce1_n;
        logic                  ce2;
        logic                  we_n;
        logic                  oe_n;
        logic                  byte_n;
        logic [ASR_ADDR_W-1:0] addr;
    } asr_pins_s;
endpackage : asr_pkg

// File: asr_sync.sv
// Two-flop synchroniser for the data bus input pins
`timescale 1ns/1ps
`default_nettype none
module asr_sync
    import asr_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [ASR_DATA_W-1:0] i_d,
    output logic      [ASR_DATA_W-1:0] o_q
);
    logic [ASR_DATA_W-1:0] meta_reg;
    logic [ASR_DATA_W-1:0] q_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;
endmodule : asr_sync
`default_nettype wire

// File: asr_ctrl.sv
// Host-side controller driving an asynchronous byte-wide SRAM
//
// Overview of operation
// - Write: ce1 low, we low, ce2 high
// - Address stable 40/60 ns before write end
// - Address may change right after write
// - Address valid at write window start
// - Data set up 25/30 ns before end
// - Time data against the closing edge
// - Never drive data while device drives
// - Width strap tied low for bytes
// - Address valid before chip select asserts
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl
    import asr_pkg::*;
#(
    parameter asr_grade_e GRADE = ASR_GRADE_45
)(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_req_valid,
    input  wire asr_req_s              i_req,
    output logic                       o_req_ready,
    output logic                       o_rd_valid,
    output logic      [ASR_DATA_W-1:0] o_rd_data,
    output asr_pins_s                  o_pins,
    input  wire logic [ASR_DATA_W-1:0] i_dq,
    output logic      [ASR_DATA_W-1:0] o_dq,
    output logic                       o_dq_oe
);
    // ****************************************
    // Grade-derived cycle counts
    // ****************************************
    localparam bit SLOW = (GRADE == ASR_GRADE_70);
    localparam int T_RC = (GRADE == ASR_GRADE_45) ? T_RC_45 :
                          (GRADE == ASR_GRADE_55) ? T_RC_55 : T_RC_70;
    localparam int T_HZ = (GRADE == ASR_GRADE_45) ? T_HZOE_45 :
                          (GRADE == ASR_GRADE_55) ? T_HZOE_55 : T_HZOE_70;
    localparam int T_PWE = (GRADE == ASR_GRADE_45) ? T_PWE_45 :
                           (GRADE == ASR_GRADE_55) ? T_PWE_55 : T_PWE_70;
    localparam int T_AW_G = SLOW ? T_AW_F + (T_AW_S - T_AW_F) : T_AW_F;
    localparam int T_SD_G = SLOW ? T_SD_S : T_SD_F;
    localparam int T_DOE_G = SLOW ? T_DOE_S : T_DOE_F;
    // Read: access time plus two synchroniser cycles
    localparam int RD_CYC = ns_to_cyc(T_RC) + 2;
    localparam int WIN_A  = ns_to_cyc(T_AW_G);
    localparam int WIN_B  = ns_to_cyc(T_PWE);
    localparam int WIN_C  = ns_to_cyc(T_SD_G);
    localparam int WR_CYC = (WIN_A > WIN_B) ? ((WIN_A > WIN_C) ? WIN_A : WIN_C)
                                            : ((WIN_B > WIN_C) ? WIN_B : WIN_C);
    localparam int TURN_CYC = ns_to_cyc(T_HZ);
    localparam int HOLD_CYC = ns_to_cyc(T_HD);
    localparam logic [7:0] RD_N   = 8'(RD_CYC);
    localparam logic [7:0] WR_N   = 8'(WR_CYC);
    localparam logic [7:0] TURN_N = 8'(TURN_CYC);
    localparam logic [7:0] HOLD_N = 8'(HOLD_CYC);
    localparam logic [7:0] SA_N   = 8'(ns_to_cyc(T_SA));

    // ****************************************
    // Sequencer
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_SETUP,
        ST_RD_WAIT,
        ST_TURN,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD
    } asr_state_e;

    asr_state_e            state_reg;
    logic [7:0]            cnt_reg;
    logic [ASR_ADDR_W-1:0] addr_reg;
    logic [ASR_DATA_W-1:0] wdata_reg;
    logic [ASR_DATA_W-1:0] dq_sync;
    logic                  sel_reg;
    logic                  we_reg;
    logic                  oe_reg;
    logic                  drive_reg;
    logic                  rd_valid_reg;
    logic [ASR_DATA_W-1:0] rd_data_reg;

    asr_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_dq),
        .o_q     (dq_sync)
    );

    assign o_req_ready = (state_reg == ST_IDLE);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (i_req_valid) begin
                        // Address goes out one cycle before select
                        state_reg <= i_req.write ? ST_WR_SETUP : ST_RD_SETUP;
                    end
                end
                ST_RD_SETUP: begin
                    state_reg <= ST_RD_WAIT;
                    cnt_reg   <= 8'h01;
                end
                ST_RD_WAIT: begin
                    if (cnt_reg >= RD_N) begin
                        state_reg <= ST_TURN;
                        cnt_reg   <= 8'h01;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                ST_TURN: begin
                    // Device outputs need time to float
                    if (cnt_reg >= TURN_N) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                ST_WR_SETUP: begin
                    if (cnt_reg + 8'h01 >= SA_N) begin
                        state_reg <= ST_WR_PULSE;
                        cnt_reg   <= 8'h01;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                ST_WR_PULSE: begin
                    if (cnt_reg >= WR_N) begin
                        state_reg <= ST_WR_HOLD;
                        cnt_reg   <= 8'h01;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                ST_WR_HOLD: begin
                    if (cnt_reg >= HOLD_N) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Address and write data latch
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
        end else if (state_reg == ST_IDLE && i_req_valid) begin
            addr_reg  <= i_req.addr;
            wdata_reg <= i_req.wdata;
        end
    end

    // ****************************************
    // Pin controls, all from flops but the tied byte_n strap
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_reg   <= 1'b0;
            we_reg    <= 1'b0;
            oe_reg    <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            // Select asserted with we/oe; we alone closes the write window
            sel_reg   <= (state_reg == ST_RD_SETUP) || (state_reg == ST_RD_WAIT && cnt_reg < RD_N)
                      || (state_reg == ST_WR_SETUP) || (state_reg == ST_WR_PULSE)
                      || (state_reg == ST_WR_HOLD && cnt_reg < HOLD_N);
            we_reg    <= (state_reg == ST_WR_SETUP)
                      || (state_reg == ST_WR_PULSE && cnt_reg < WR_N);
            oe_reg    <= (state_reg == ST_RD_SETUP)
                      || (state_reg == ST_RD_WAIT && cnt_reg < RD_N);
            // Drive only in write states, never while oe is low
            drive_reg <= (state_reg == ST_WR_SETUP) || (state_reg == ST_WR_PULSE)
                      || (state_reg == ST_WR_HOLD && cnt_reg < HOLD_N);
        end
    end

    always_comb begin
        o_pins.ce1_n  = ~sel_reg;
        o_pins.ce2    = sel_reg;
        o_pins.we_n   = ~we_reg;
        o_pins.oe_n   = ~oe_reg;
        o_pins.byte_n = 1'b0;
        o_pins.addr   = addr_reg;
    end
    assign o_dq    = wdata_reg;
    assign o_dq_oe = drive_reg;

    // ****************************************
    // Read capture
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= '0;
        end else begin
            rd_valid_reg <= (state_reg == ST_RD_WAIT && cnt_reg == RD_N);
            if (state_reg == ST_RD_WAIT && cnt_reg == RD_N) begin
                rd_data_reg <= dq_sync;
            end
        end
    end
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data  = rd_data_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_no_contention: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(o_dq_oe && !o_pins.oe_n)) else $error("data driven while oe low");
    a_byte_strap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_pins.byte_n) else $error("width strap not low");
    a_we_needs_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_pins.we_n |-> (!o_pins.ce1_n && o_pins.ce2 && o_dq_oe))
        else $error("we low without select or data");
    a_addr_write_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!o_pins.we_n && !$past(o_pins.we_n)) |-> $stable(o_pins.addr))
        else $error("address moved during write");
    a_addr_before_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_pins.ce1_n) |-> $stable(o_pins.addr)) else $error("address changed at select");
    a_write_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_pins.we_n) |-> !o_pins.we_n [*3]) else $error("write pulse too short");
    a_data_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!o_pins.we_n) |-> $stable(o_dq)) else $error("write data moved");
    a_read_return: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_req_ready && i_req_valid && !i_req.write) |-> ##[2:12] o_rd_valid)
        else $error("read data late");
    a_oe_we_excl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(!o_pins.oe_n && !o_pins.we_n)) else $error("oe and we both low");
endmodule : asr_ctrl
`default_nettype wire

// File: asr_sram_model.sv
// Behavioural model of the byte-wide asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
    import asr_pkg::*;
#(
    parameter int TAA  = T_RC_45,
    parameter int TOE  = T_DOE_F,
    parameter int THZ  = T_HZOE_45,
    parameter int TAW  = T_AW_F,
    parameter int TSD  = T_SD_F,
    parameter int TPWE = T_PWE_45
)(
    input  wire asr_pins_s             i_pins,
    input  wire logic [ASR_DATA_W-1:0] i_dq,
    input  wire logic                  i_dq_oe,
    output logic      [ASR_DATA_W-1:0] o_bus,
    output int                         o_viol
);
    // Sparse store: only written bytes occupy memory
    logic [ASR_DATA_W-1:0] mem [int];
    logic [ASR_DATA_W-1:0] q;
    logic [ASR_ADDR_W-1:0] a_last;
    logic [ASR_DATA_W:0]   d_last;
    logic                  sel, drv, drv_last, wr, wr_last, dev_oe;
    realtime               t_a, t_d, t_oe, t_off, t_wr, now;

    // ****************************************
    // Pin evaluation on a 1 ns grid, off the clock edges
    // ****************************************
    initial begin
        o_viol = 0;
        q = 8'h00;
        o_bus = 8'h00;
        a_last = '0;
        d_last = '0;
        drv_last = 1'b0;
        wr_last = 1'b0;
        t_a = 0;
        t_d = 0;
        t_oe = 0;
        t_wr = 0;
        t_off = -100;
        #0.5;
        forever begin
            now = $realtime;
            sel = !i_pins.ce1_n && i_pins.ce2;
            drv = sel && !i_pins.oe_n && i_pins.we_n;
            wr = sel && !i_pins.we_n;
            if (i_pins.addr !== a_last) begin
                if (wr) o_viol++;
                a_last = i_pins.addr;
                t_a = now;
            end
            if ({i_dq_oe, i_dq} !== d_last) begin
                d_last = {i_dq_oe, i_dq};
                t_d = now;
            end
            if (drv && !drv_last) t_oe = now;
            if (!drv && drv_last) t_off = now;
            if (wr && !wr_last) t_wr = now;
            if (!wr && wr_last) begin
                if (now - t_a < TAW || now - t_d < TSD || now - t_wr < TPWE || !i_dq_oe)
                    o_viol++;
                mem[int'(a_last)] = i_dq;
            end
            drv_last = drv;
            wr_last = wr;
            // Outputs linger after disable, so an early turnaround collides
            dev_oe = drv || (now - t_off < THZ);
            if (dev_oe && i_dq_oe) o_viol++;
            if (now - t_a >= 10) begin
                if (drv && now - t_a >= TAA && now - t_oe >= TOE)
                    q = mem.exists(int'(a_last)) ? mem[int'(a_last)] : 8'h5a;
                else
                    q = ~q;
            end
            // Undriven bus shows no stale value
            o_bus = i_dq_oe ? i_dq : (dev_oe ? q : ~o_bus);
            #1;
        end
    end
endmodule : asr_sram_model
`default_nettype wire

// File: tb_asr_ctrl.sv
// Self-checking testbench for the SRAM controller
`timescale 1ns/1ps
`default_nettype none
module tb_asr_ctrl;
    import asr_pkg::*;
    logic                  i_clk, i_rst_n, i_req_valid, o_req_ready, o_rd_valid, o_dq_oe;
    asr_req_s              i_req;
    asr_pins_s             o_pins;
    logic [ASR_DATA_W-1:0] o_rd_data, o_dq, bus;
    int                    viol, n_fail, check_count;

    asr_ctrl #(.GRADE(ASR_GRADE_45)) u_asr_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
        .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_pins(o_pins),
        .i_dq(bus), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
    asr_sram_model u_asr_sram_model (.i_pins(o_pins), .i_dq(o_dq), .i_dq_oe(o_dq_oe),
        .o_bus(bus), .o_viol(viol));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Called at a falling edge; returns at the falling edge after the take
    task automatic req(input logic wr, input logic [19:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        i_req_valid = 1'b1;
        i_req = '{write: wr, addr: a, wdata: d};
        @(negedge i_clk);
        i_req_valid = 1'b0;
    endtask : req

    task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
        int n;
        req(1'b0, a, 8'h00);
        n = 0;
        while (o_rd_valid !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        // Select cycle, access time, then two synchroniser stages
        chk(n, ns_to_cyc(T_RC_45) + 3);
        chk(o_rd_data, exp);
    endtask : rd_chk

    task automatic t_idle();
        chk(o_pins.ce1_n, 1'b1);
        chk(o_pins.ce2, 1'b0);
        chk({o_pins.we_n, o_pins.oe_n}, 2'b11);
        chk(o_dq_oe, 1'b0);
        chk(o_req_ready, 1'b1);
        chk(o_pins.byte_n, 1'b0);
    endtask : t_idle

    task automatic t_rw();
        logic [19:0] a[4] = '{20'h00000, 20'hfffff, 20'h12345, 20'h80000};
        logic [7:0]  d[4] = '{8'ha5, 8'hff, 8'h00, 8'h3c};
        for (int i = 0; i < 4; i++) req(1'b1, a[i], d[i]);
        for (int i = 0; i < 4; i++) rd_chk(a[i], d[i]);
        $display("test rw done");
    endtask : t_rw

    task automatic t_b2b();
        req(1'b1, 20'h00001, 8'h11);
        req(1'b1, 20'h00001, 8'h96);
        rd_chk(20'h00001, 8'h96);
        rd_chk(20'h00000, 8'ha5);
        $display("test back_to_back done");
    endtask : t_b2b

    task automatic t_hold();
        // Payload changes while busy must not leak into the taken request
        req(1'b1, 20'h00002, 8'h4b);
        i_req = '{write: 1'b1, addr: 20'h00003, wdata: 8'he7};
        @(negedge i_clk);
        rd_chk(20'h00002, 8'h4b);
        rd_chk(20'h00003, 8'h5a);
        $display("test hold done");
    endtask : t_hold

    task automatic t_abort();
        req(1'b1, 20'h12345, 8'h77);
        i_rst_n = 1'b0;
        #1;
        t_idle();
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        rd_chk(20'h12345, 8'h00);
        $display("test abort done");
    endtask : t_abort

    initial begin
        n_fail = 0;
        check_count = 0;
        i_rst_n = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        repeat (4) @(negedge i_clk);
        t_idle();
        i_rst_n = 1'b1;
        @(negedge i_clk);
        $display("test reset done");
        t_rw();
        t_b2b();
        t_hold();
        t_abort();
        chk(viol, 0);
        tally_and_finish();
    end

    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule : tb_asr_ctrl
`default_nettype wire
